// [hw/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

  // Register addresses on the plain register port (word addresses).
  localparam logic [4:0] ADDR_STATUS   = 5'h00;
  localparam logic [4:0] ADDR_CORE     = 5'h01;
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h02;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h03;
  localparam logic [4:0] ADDR_FLAGS0   = 5'h04;
  localparam logic [4:0] ADDR_FLAGS1   = 5'h05;
  localparam logic [4:0] ADDR_FLAGS4   = 5'h06;
  localparam logic [4:0] ADDR_ENABLE0  = 5'h08;
  localparam logic [4:0] ADDR_ENABLE1  = 5'h09;
  localparam logic [4:0] ADDR_ENABLE4  = 5'h0a;
  localparam logic [4:0] ADDR_PRIO0    = 5'h10;
  localparam logic [4:0] ADDR_PENDING  = 5'h1f;

  // Source count, register counts and the vector base.
  localparam int NUM_SRC    = 72;
  localparam int NUM_FLAGW  = 5;
  localparam int NUM_PRIOW  = 18;
  localparam int VEC_BASE   = 8;

  // Implemented-bit masks of the flag and enable words 0, 1 and 4, the priority-word mask and the priority reset value.
  localparam logic [15:0] MASK_W0 = 16'h3fef;
  localparam logic [15:0] MASK_W1 = 16'h20db;
  localparam logic [15:0] MASK_W4 = 16'h0002;
  localparam logic [15:0] MASK_PRIO = 16'h7777;
  localparam logic [15:0] PRIO_RESET = 16'h4444;

  // Field positions.
  localparam int CPL_LO       = 5;
  localparam int CORE_TOP_BIT = 3;
  localparam int NEST_DIS_BIT = 15;
  localparam int DIV0_BIT     = 6;
  localparam int MATH_BIT     = 4;
  localparam int ADDR_BIT     = 3;
  localparam int STACK_BIT    = 2;
  localparam int OSC_BIT      = 1;
  localparam int ALT_TBL_BIT  = 15;
  localparam int DISABLE_INSTRUCTION_ACTIVE_BIT     = 14;

  // Sources wired to the external request pins.
  localparam int EXT0_SRC = 0;
  localparam int EXT1_SRC = 20;
  localparam int EXT2_SRC = 29;

endpackage

// [hw/edge_sense.sv]
`timescale 1ns/1ps
// Synchronises one external request pin and flags the selected edge.
module edge_sense (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and polarity
  input  wire logic pin,
  input  wire logic negative,
  // Edge event
  output logic      edge_seen
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } state_t;

  state_t st_reg;
  state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign edge_seen = negative ? (st_reg.s3 & ~st_reg.s2)
                              : (~st_reg.s3 & st_reg.s2);
endmodule

// [hw/prio_pick.sv]
`timescale 1ns/1ps
// Finds the highest-priority live request; ties go to the lower index.
module prio_pick #(
  parameter int N = 72
) (
  // Requests
  input  wire logic [N-1:0]   live,
  input  wire logic [3*N-1:0] prio,
  // Winner
  output logic                found,
  output logic [6:0]          index,
  output logic [2:0]          level
);
  initial begin
    if (N < 1 || N > 118) begin
      $error("prio_pick: N out of range");
    end
  end

  always_comb begin
    found = 1'b0;
    index = 7'h00;
    level = 3'h0;
    for (int i = 0; i < N; i++) begin
      // Strict compare keeps the lowest index among equals.
      if (live[i] && (!found || prio[3*i +: 3] > level)) begin
        found = 1'b1;
        index = 7'(i);
        level = prio[3*i +: 3];
      end
    end
  end
endmodule

// [hw/irq_ctrl_regs.sv]
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Source flags set by events, software clears.
// - Cleared enable bit blocks the source.
// - Each source has eight-level priority field.
// - Priority seven highest, zero disables source.
// - Pending register holds vector and level.
// - Bits follow vector order, source zero first.
// - Equal priority: lower vector position wins.
// - CPU level low bits at status 7:5.
// - Software cannot write one to top bit.
// - Top bit set blocks all user requests.
// - Level field 111 blocks user requests.
// - Nesting disable is control one bit 15.
// - Nesting disable makes low level read-only.
// - Trap flags in control one bits 1-4 and 6.
// - Control two bit 15 selects alternate table.
// - Unimplemented bits read zero, ignore writes.
module irq_ctrl_regs #(
  parameter int NUM_SRC = irq_ctrl_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Peripheral events and external pins
  input  wire logic [NUM_SRC-1:0] src_event,
  input  wire logic [2:0]  ext_pin,
  // Trap events and the disable-instruction status from the core
  input  wire logic        osc_fail,
  input  wire logic        stack_err,
  input  wire logic        addr_err,
  input  wire logic        math_err,
  input  wire logic        div_zero,
  input  wire logic        disable_instruction_active_active,
  // CPU handshake
  output logic             cpu_req,
  output logic      [6:0]  cpu_vector,
  output logic      [3:0]  cpu_level,
  output logic             alt_table,
  input  wire logic        cpu_ack,
  input  wire logic        trap_enter
);
  initial begin
    if (NUM_SRC != irq_ctrl_pkg::NUM_SRC) begin
      $error("irq_ctrl_regs: source count must match the map");
    end
  end

  localparam int NP = irq_ctrl_pkg::NUM_PRIOW;
  localparam logic [79:0] IMPL_ALL = {irq_ctrl_pkg::MASK_W4, 16'h0000,
                                      16'h0000, irq_ctrl_pkg::MASK_W1,
                                      irq_ctrl_pkg::MASK_W0};

  typedef struct packed {
    logic [NUM_SRC-1:0]   flags;
    logic [NUM_SRC-1:0]   enables;
    logic [3*NUM_SRC-1:0] prios;
    logic [2:0]           cpl_low;
    logic                 cpl_top;
    logic                 nest_dis;
    logic [4:0]           traps;
    logic                 alt_tbl;
    logic [2:0]           ext_pol;
    logic [6:0]           pend_vec;
    logic [3:0]           pend_lvl;
    logic [15:0]          rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [NUM_SRC-1:0] impl_mask;
  logic [NUM_SRC-1:0] events;
  logic [NUM_SRC-1:0] live;
  logic [2:0]         ext_edge;
  logic               found;
  logic [6:0]         win_idx;
  logic [2:0]         win_lvl;
  logic [3:0]         cur_level;
  logic [15:0]        rd_word;
  logic [4:0]         prio_word;
  logic               prio_hit;

  assign impl_mask = IMPL_ALL[NUM_SRC-1:0];

  // Each priority word holds four sources, one nibble each, bit 3 unused.
  assign prio_word = addr - irq_ctrl_pkg::ADDR_PRIO0;
  assign prio_hit  = (addr >= irq_ctrl_pkg::ADDR_PRIO0) &&
                     (prio_word < 5'(NP));

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ext
      edge_sense u_edge (
        .clk       (clk),
        .rst       (rst),
        .pin       (ext_pin[g]),
        .negative  (st_reg.ext_pol[g]),
        .edge_seen (ext_edge[g])
      );
    end
  endgenerate

  always_comb begin
    events = src_event;
    events[irq_ctrl_pkg::EXT0_SRC] = ext_edge[0];
    events[irq_ctrl_pkg::EXT1_SRC] = ext_edge[1];
    events[irq_ctrl_pkg::EXT2_SRC] = ext_edge[2];
  end

  assign cur_level = {st_reg.cpl_top, st_reg.cpl_low};

  // A zero field disables the source; only strictly higher levels pass.
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      live[i] = st_reg.flags[i] & st_reg.enables[i]
              & (st_reg.prios[3*i +: 3] != 3'h0)
              & ({1'b0, st_reg.prios[3*i +: 3]} > cur_level);
    end
  end

  prio_pick #(
    .N (NUM_SRC)
  ) u_pick (
    .live  (live),
    .prio  (st_reg.prios),
    .found (found),
    .index (win_idx),
    .level (win_lvl)
  );

  // Top bit or a level of seven leaves no source able to exceed it.
  assign cpu_req    = found & ~st_reg.cpl_top;
  assign cpu_vector = st_reg.pend_vec;
  assign cpu_level  = cur_level;
  assign alt_table  = st_reg.alt_tbl;
  assign rdata      = st_reg.rdata;

  always_comb begin
    rd_word = 16'h0000;
    case (addr)
      irq_ctrl_pkg::ADDR_STATUS:
        rd_word[irq_ctrl_pkg::CPL_LO +: 3] = st_reg.cpl_low;
      irq_ctrl_pkg::ADDR_CORE:
        rd_word[irq_ctrl_pkg::CORE_TOP_BIT] = st_reg.cpl_top;
      irq_ctrl_pkg::ADDR_CTRL_ONE: begin
        rd_word[irq_ctrl_pkg::NEST_DIS_BIT] = st_reg.nest_dis;
        rd_word[irq_ctrl_pkg::DIV0_BIT]  = st_reg.traps[4];
        rd_word[irq_ctrl_pkg::MATH_BIT]  = st_reg.traps[3];
        rd_word[irq_ctrl_pkg::ADDR_BIT]  = st_reg.traps[2];
        rd_word[irq_ctrl_pkg::STACK_BIT] = st_reg.traps[1];
        rd_word[irq_ctrl_pkg::OSC_BIT]   = st_reg.traps[0];
      end
      irq_ctrl_pkg::ADDR_CTRL_TWO: begin
        rd_word[irq_ctrl_pkg::ALT_TBL_BIT] = st_reg.alt_tbl;
        rd_word[irq_ctrl_pkg::DISABLE_INSTRUCTION_ACTIVE_BIT]    = disable_instruction_active_active;
        rd_word[2:0] = st_reg.ext_pol;
      end
      irq_ctrl_pkg::ADDR_FLAGS0:  rd_word = st_reg.flags[15:0];
      irq_ctrl_pkg::ADDR_FLAGS1:  rd_word = st_reg.flags[31:16];
      irq_ctrl_pkg::ADDR_FLAGS4:  rd_word = {8'h00, st_reg.flags[71:64]};
      irq_ctrl_pkg::ADDR_ENABLE0: rd_word = st_reg.enables[15:0];
      irq_ctrl_pkg::ADDR_ENABLE1: rd_word = st_reg.enables[31:16];
      irq_ctrl_pkg::ADDR_ENABLE4: rd_word = {8'h00, st_reg.enables[71:64]};
      irq_ctrl_pkg::ADDR_PENDING:
        rd_word = {1'b0, st_reg.pend_lvl, 4'h0, st_reg.pend_vec};
      default: begin
        if (prio_hit) begin
          for (int j = 0; j < 4; j++) begin
            if (4 * int'(prio_word) + j < NUM_SRC) begin
              rd_word[4*j +: 3] =
                st_reg.prios[3*(4*int'(prio_word) + j) +: 3];
            end
          end
        end
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.rdata = rd ? rd_word : st_reg.rdata;
    // Software writes, masked to the implemented bits.
    if (wr) begin
      case (addr)
        irq_ctrl_pkg::ADDR_STATUS:
          if (!st_reg.nest_dis) begin
            st_next.cpl_low = wdata[irq_ctrl_pkg::CPL_LO +: 3];
          end
        irq_ctrl_pkg::ADDR_CORE:
          // Ones are ignored; a zero clears the top bit.
          if (!wdata[irq_ctrl_pkg::CORE_TOP_BIT]) begin
            st_next.cpl_top = 1'b0;
          end
        irq_ctrl_pkg::ADDR_CTRL_ONE: begin
          st_next.nest_dis = wdata[irq_ctrl_pkg::NEST_DIS_BIT];
          st_next.traps = {wdata[irq_ctrl_pkg::DIV0_BIT],
                           wdata[irq_ctrl_pkg::MATH_BIT],
                           wdata[irq_ctrl_pkg::ADDR_BIT],
                           wdata[irq_ctrl_pkg::STACK_BIT],
                           wdata[irq_ctrl_pkg::OSC_BIT]};
        end
        irq_ctrl_pkg::ADDR_CTRL_TWO: begin
          st_next.alt_tbl = wdata[irq_ctrl_pkg::ALT_TBL_BIT];
          st_next.ext_pol = wdata[2:0];
        end
        irq_ctrl_pkg::ADDR_FLAGS0:
          st_next.flags[15:0] = wdata & irq_ctrl_pkg::MASK_W0;
        irq_ctrl_pkg::ADDR_FLAGS1:
          st_next.flags[31:16] = wdata & irq_ctrl_pkg::MASK_W1;
        irq_ctrl_pkg::ADDR_FLAGS4:
          st_next.flags[71:64] = wdata[7:0] & irq_ctrl_pkg::MASK_W4[7:0];
        irq_ctrl_pkg::ADDR_ENABLE0:
          st_next.enables[15:0] = wdata & irq_ctrl_pkg::MASK_W0;
        irq_ctrl_pkg::ADDR_ENABLE1:
          st_next.enables[31:16] = wdata & irq_ctrl_pkg::MASK_W1;
        irq_ctrl_pkg::ADDR_ENABLE4:
          st_next.enables[71:64] = wdata[7:0] & irq_ctrl_pkg::MASK_W4[7:0];
        default: begin
          if (prio_hit) begin
            for (int j = 0; j < 4; j++) begin
              if (4 * int'(prio_word) + j < NUM_SRC) begin
                st_next.prios[3*(4*int'(prio_word) + j) +: 3] =
                  wdata[4*j +: 3];
              end
            end
          end
        end
      endcase
    end
    // Hardware sets come after the software write so a set wins.
    st_next.flags = st_next.flags | (events & impl_mask);
    if (osc_fail)  st_next.traps[0] = 1'b1;
    if (stack_err) st_next.traps[1] = 1'b1;
    if (addr_err)  st_next.traps[2] = 1'b1;
    if (math_err)  st_next.traps[3] = 1'b1;
    if (div_zero)  st_next.traps[4] = 1'b1;
    // Unimplemented priority fields stay zero.
    for (int i = 0; i < NUM_SRC; i++) begin
      if (!impl_mask[i]) begin
        st_next.prios[3*i +: 3] = 3'h0;
      end
    end
    // Latch the current winner for the core.
    if (found) begin
      st_next.pend_vec = 7'(win_idx + 7'(irq_ctrl_pkg::VEC_BASE));
      st_next.pend_lvl = {1'b0, win_lvl};
    end
    // Taking the request raises the CPU level to the winner's level.
    if (cpu_ack && cpu_req) begin
      st_next.cpl_low = st_reg.pend_lvl[2:0];
    end
    // Trap entry raises the level above every user level.
    if (trap_enter) begin
      st_next.cpl_top = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg       <= '0;
      // Unimplemented fields are cleared by the next cycle's mask.
      st_reg.prios <= {NUM_SRC{3'h4}};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// [tb/irq_ctrl_regs_asserts.sv]
`timescale 1ns/1ps
module irq_ctrl_regs_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // CPU side
  input wire logic        cpu_req,
  input wire logic [3:0]  cpu_level,
  input wire logic        alt_table,
  input wire logic        cpu_ack,
  input wire logic        trap_enter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic nest_reg;
  logic st_wr;
  // Shadow of the nesting-disable bit, since the checker sees ports only.
  always_ff @(posedge clk) begin
    if (rst) begin
      nest_reg <= 1'b0;
    end else if (wr && addr == irq_ctrl_pkg::ADDR_CTRL_ONE) begin
      nest_reg <= wdata[15];
    end
  end
  assign st_wr = wr && addr == irq_ctrl_pkg::ADDR_STATUS && !cpu_ack
                 && !trap_enter;
  property p_top_blocks;
    cpu_level[3] |-> !cpu_req;
  endproperty
  a_top_blocks: assert property (p_top_blocks) else $error("top bit");
  property p_l7_blocks;
    cpu_level[2:0] == 3'h7 |-> !cpu_req;
  endproperty
  a_l7_blocks: assert property (p_l7_blocks) else $error("level 7");
  property p_level_wr;
    st_wr && !nest_reg |=> cpu_level[2:0] == $past(wdata[7:5]);
  endproperty
  a_level_wr: assert property (p_level_wr) else $error("level wr");
  property p_level_ro;
    st_wr && nest_reg |=> $stable(cpu_level);
  endproperty
  a_level_ro: assert property (p_level_ro) else $error("level ro");
  property p_top_wr1;
    wr && addr == irq_ctrl_pkg::ADDR_CORE && !cpu_level[3] && !trap_enter
      |=> !cpu_level[3];
  endproperty
  a_top_wr1: assert property (p_top_wr1) else $error("top wr");
  property p_status_rd;
    rd && addr == irq_ctrl_pkg::ADDR_STATUS
      |=> rdata[7:5] == $past(cpu_level[2:0]);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status rd");
  property p_alt;
    wr && addr == irq_ctrl_pkg::ADDR_CTRL_TWO |=> alt_table == $past(wdata[15]);
  endproperty
  a_alt: assert property (p_alt) else $error("alt table");
  property p_flags4_rd;
    rd && addr == irq_ctrl_pkg::ADDR_FLAGS4
      |=> (rdata & ~irq_ctrl_pkg::MASK_W4) == 16'h0000;
  endproperty
  a_flags4_rd: assert property (p_flags4_rd) else $error("unused bits");
endmodule

bind irq_ctrl_regs irq_ctrl_regs_asserts u_irq_ctrl_regs_asserts (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .cpu_req(cpu_req), .cpu_level(cpu_level),
  .alt_table(alt_table), .cpu_ack(cpu_ack), .trap_enter(trap_enter));

// [tb/cpu_core_model.sv]
`timescale 1ns/1ps
// Core side: takes a request after it has stood three cycles, one pulse.
module cpu_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic cpu_req,
  input wire logic take_en,
  // Acceptance
  output logic     cpu_ack
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk) begin
    if (rst || !take_en || !cpu_req || cpu_ack) begin
      wait_reg <= 2'h0;
      cpu_ack <= 1'b0;
    end else if (wait_reg == 2'h2) begin
      cpu_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// [tb/irq_ctrl_regs_tb_top.sv]
`timescale 1ns/1ps
module irq_ctrl_regs_tb_top;
  logic        clk;
  logic        rst;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [71:0] src_event;
  logic [2:0]  ext_pin;
  logic [4:0]  trap;
  logic        disable_instruction_active_active;
  logic        cpu_req;
  logic [3:0]  cpu_level;
  logic [6:0]  cpu_vector;
  logic        alt_table;
  logic        cpu_ack;
  logic        trap_enter;
  logic        take_en;
  int          num_errors;
  int          num_checks;

  irq_ctrl_regs u_irq_ctrl_regs (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src_event(src_event),
    .ext_pin(ext_pin), .osc_fail(trap[0]), .stack_err(trap[1]),
    .addr_err(trap[2]), .math_err(trap[3]), .div_zero(trap[4]),
    .disable_instruction_active_active(disable_instruction_active_active), .cpu_req(cpu_req), .cpu_vector(cpu_vector),
    .cpu_level(cpu_level), .alt_table(alt_table), .cpu_ack(cpu_ack),
    .trap_enter(trap_enter));
  cpu_core_model u_cpu_core_model (.clk(clk), .rst(rst), .cpu_req(cpu_req),
    .take_en(take_en), .cpu_ack(cpu_ack));

  always #50 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_t(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd_t(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic req_is(input logic exp);
    #1;
    chk({15'h0, cpu_req}, {15'h0, exp});
  endtask
  task automatic ev(input int i);
    @(posedge clk);
    src_event[i] <= 1'b1;
    @(posedge clk);
    src_event[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic results();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_flag();
    rd_t(irq_ctrl_pkg::ADDR_PRIO0, 16'h4444);
    ev(3);
    rd_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0008);
    req_is(1'b0);
    wr_t(irq_ctrl_pkg::ADDR_ENABLE0, 16'h0008);
    req_is(1'b1);
    rd_t(irq_ctrl_pkg::ADDR_PENDING, 16'h200b);
    wr_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0000);
    req_is(1'b0);
  endtask
  task automatic t_tie();
    wr_t(irq_ctrl_pkg::ADDR_ENABLE0, 16'h0006);
    ev(1);
    ev(2);
    rd_t(irq_ctrl_pkg::ADDR_PENDING, 16'h2009);
    wr_t(irq_ctrl_pkg::ADDR_PRIO0, 16'h4644);
    rd_t(irq_ctrl_pkg::ADDR_PENDING, 16'h300a);
    chk({9'h000, cpu_vector}, 16'h000a);
    wr_t(irq_ctrl_pkg::ADDR_PRIO0, 16'h4074);
    rd_t(irq_ctrl_pkg::ADDR_PENDING, 16'h3809);
    chk({9'h000, cpu_vector}, 16'h0009);
  endtask
  task automatic t_level();
    wr_t(irq_ctrl_pkg::ADDR_STATUS, 16'h00e0);
    req_is(1'b0);
    wr_t(irq_ctrl_pkg::ADDR_STATUS, 16'h00c0);
    rd_t(irq_ctrl_pkg::ADDR_STATUS, 16'h00c0);
    req_is(1'b1);
    wr_t(irq_ctrl_pkg::ADDR_CTRL_ONE, 16'h8000);
    wr_t(irq_ctrl_pkg::ADDR_STATUS, 16'h0000);
    rd_t(irq_ctrl_pkg::ADDR_STATUS, 16'h00c0);
    rd_t(irq_ctrl_pkg::ADDR_CTRL_ONE, 16'h8000);
    wr_t(irq_ctrl_pkg::ADDR_CTRL_ONE, 16'h0000);
    wr_t(irq_ctrl_pkg::ADDR_STATUS, 16'h0000);
  endtask
  task automatic t_trap();
    trap <= 5'h1f;
    @(posedge clk);
    trap <= 5'h00;
    rd_t(irq_ctrl_pkg::ADDR_CTRL_ONE, 16'h005e);
    trap_enter <= 1'b1;
    @(posedge clk);
    trap_enter <= 1'b0;
    rd_t(irq_ctrl_pkg::ADDR_CORE, 16'h0008);
    req_is(1'b0);
    wr_t(irq_ctrl_pkg::ADDR_CORE, 16'h0000);
    wr_t(irq_ctrl_pkg::ADDR_CORE, 16'h0008);
    rd_t(irq_ctrl_pkg::ADDR_CORE, 16'h0000);
    take_en <= 1'b1;
    repeat (8) @(posedge clk);
    take_en <= 1'b0;
    chk({12'h0, cpu_level}, 16'h0007);
    req_is(1'b0);
  endtask
  task automatic t_ctrl2();
    wr_t(irq_ctrl_pkg::ADDR_CTRL_TWO, 16'hffff);
    chk({15'h0, alt_table}, 16'h0001);
    rd_t(irq_ctrl_pkg::ADDR_CTRL_TWO, 16'hc007);
    wr_t(irq_ctrl_pkg::ADDR_FLAGS4, 16'hffff);
    rd_t(irq_ctrl_pkg::ADDR_FLAGS4, 16'h0002);
    wr_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0000);
    ext_pin <= 3'h1;
    rd_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0000);
    ext_pin <= 3'h0;
    rd_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0000);
    rd_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0001);
    wr_t(irq_ctrl_pkg::ADDR_CTRL_TWO, 16'h0000);
    wr_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0000);
    ext_pin <= 3'h1;
    repeat (4) @(posedge clk);
    rd_t(irq_ctrl_pkg::ADDR_FLAGS0, 16'h0001);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {addr, wdata, wr, rd, src_event, ext_pin, trap} = '0;
    {trap_enter, take_en, num_errors, num_checks} = '0;
    disable_instruction_active_active = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_flag();
    t_tie();
    t_level();
    t_trap();
    t_ctrl2();
    results();
  end
  initial begin
    #200000;
    num_errors++;
    results();
  end
endmodule
